/* File: hw/sync_fifo_status_flags.v */
// Operation
// R1: Ganged devices share all input controls.
// R2: Combine empty flags, and full flags separately.
// R3: Almost flags may come from one device.
// R4: Second read enable may be grounded.
// R5: Hold load pin low in reset.
// R6: Four flags, all registered.
// R7: Full flag low when storage full.
// R8: Writes ignored while full.
// R9: Full flag updated on write clock.
// R10: Empty flag low when storage empty.
// R11: Reads ignored while empty.
// R12: Empty flag updated on read clock.
// R13: Offset readback cycles same byte order.
// R14: Almost-empty offset defaults to seven.
// R15: Almost-full offset defaults to seven.
// R16: Write needs enable a low, b high, not full.
// R17: Offset writes cycle four bytes, then wrap.
// R18: Empty keeps last read data on outputs.
// R19: Reset empties device, empty flag low.
// R20: Composite flags low if any device low.
`timescale 1ns/10ps
`include "sync_fifo_status_flags_regs.vh"
module sync_fifo_status_flags #(
	parameter WIDTH = `FIFO_WIDTH,
	parameter ABITS = `FIFO_ADDR_BITS
) (
	// Clock and reset
	input wire ref_clk,
	input wire reset_n,
	// Write port
	input wire write_enable_a_n,
	input wire write_enable_b_or_load,
	input wire [WIDTH-1:0] write_data_in,
	// Read port
	input wire read_enable_a_n,
	input wire read_enable_b_n,
	output reg [WIDTH-1:0] read_data_out,
	// Flags
	output reg empty_flag_n,
	output reg full_indicator_n,
	output reg almost_empty_flag_n,
	output reg almost_full_flag_n,
	// Configuration caught at reset release
	output reg load_mode
);
	localparam DEPTH = 1 << ABITS;
	localparam [ABITS:0] DEPTH_C = {1'b1, {ABITS{1'b0}}};

	// ****************************************
	// Reset synchroniser
	// ****************************************
	reg rst_meta_r;
	reg rst_sync_r;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	wire rst_n = rst_sync_r;

	// ****************************************
	// Storage and state
	// ****************************************
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [ABITS-1:0] wr_ptr_r;
	reg [ABITS-1:0] rd_ptr_r;
	reg [ABITS:0] count_r;
	reg [`OFFSET_BITS-1:0] empty_off_r;
	reg [`OFFSET_BITS-1:0] full_off_r;
	reg [1:0] wr_sel_r;
	reg [1:0] rd_sel_r;
	reg in_reset_r;

	// Pin mode: load pin low during reset means offset programming
	wire load_active = load_mode && !write_enable_b_or_load;
	wire write_req = !write_enable_a_n && (load_mode || write_enable_b_or_load) && !load_active;
	wire read_req = !read_enable_a_n && !read_enable_b_n;
	wire do_write = write_req && full_indicator_n; // see R8 see R16
	wire do_read = read_req && empty_flag_n && !load_active; // see R11
	wire off_write = load_active && !write_enable_a_n;
	// Readback only when not also writing, which the user must avoid
	wire off_read = load_active && read_req && !off_write; // see R13

	wire [ABITS:0] count_nxt = count_r + {{ABITS{1'b0}}, do_write} - {{ABITS{1'b0}}, do_read};

	// Strap caught by clocked logic while reset holds
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_reset_r <= 1'b1;
		end else begin
			in_reset_r <= 1'b0;
		end
	end
	always @(posedge ref_clk) begin
		if (in_reset_r) begin
			load_mode <= !write_enable_b_or_load; // see R5
		end
	end

	// ****************************************
	// Data path
	// ****************************************
	localparam [ABITS-1:0] PTR_ONE = {{(ABITS-1){1'b0}}, 1'b1};
	reg [ABITS-1:0] wr_ptr_nxt;
	reg [ABITS-1:0] rd_ptr_nxt;
	reg [WIDTH-1:0] read_data_nxt;
	reg [7:0] sel_byte;
	wire [WIDTH-1:0] offset_byte_w;

	always @(posedge ref_clk) begin
		if (do_write) begin // see R16
			mem[wr_ptr_r] <= write_data_in;
		end
	end

	// Pointers move only on accepted transfers
	always @* begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		if (do_write) begin // see R8
			wr_ptr_nxt = wr_ptr_r + PTR_ONE;
		end
		if (do_read) begin // see R11
			rd_ptr_nxt = rd_ptr_r + PTR_ONE;
		end
	end

	// Offset byte for readback, same order as writing
	always @* begin
		case (rd_sel_r)
		`SEL_EMPTY_LO: begin
			sel_byte = empty_off_r[7:0];
		end
		`SEL_EMPTY_HI: begin
			sel_byte = {2'h0, empty_off_r[13:8]};
		end
		`SEL_FULL_LO: begin
			sel_byte = full_off_r[7:0];
		end
		default: begin
			sel_byte = {2'h0, full_off_r[13:8]};
		end
		endcase
	end

	// Upper data bits read back as zero
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : pad_g
			if (gi < 8) begin : byte_g
				assign offset_byte_w[gi] = sel_byte[gi];
			end else begin : zero_g
				assign offset_byte_w[gi] = 1'b0;
			end
		end
	endgenerate

	// Output holds last word unless a read or readback happens
	always @* begin
		read_data_nxt = read_data_out;
		if (do_read) begin // see R18
			read_data_nxt = mem[rd_ptr_r];
		end else if (off_read) begin // see R13
			read_data_nxt = offset_byte_w;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= {ABITS{1'b0}};
			rd_ptr_r <= {ABITS{1'b0}};
			count_r <= {(ABITS+1){1'b0}};
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
	end

	// Data outputs go low in reset, like the pins after a reset cycle
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_data_out <= {WIDTH{1'b0}};
		end else begin
			read_data_out <= read_data_nxt;
		end
	end

	// ****************************************
	// Offset registers
	// ****************************************
	reg [1:0] wr_sel_nxt;
	reg [1:0] rd_sel_nxt;
	reg [`OFFSET_BITS-1:0] empty_off_nxt;
	reg [`OFFSET_BITS-1:0] full_off_nxt;

	// Separate write and read sequence pointers; a partial
	// update leaves the write pointer mid-sequence
	always @* begin
		wr_sel_nxt = wr_sel_r;
		rd_sel_nxt = rd_sel_r;
		empty_off_nxt = empty_off_r;
		full_off_nxt = full_off_r;
		if (off_write) begin // see R17
			wr_sel_nxt = wr_sel_r + 2'h1;
			case (wr_sel_r)
			`SEL_EMPTY_LO: begin
				empty_off_nxt[7:0] = write_data_in[7:0];
			end
			`SEL_EMPTY_HI: begin
				empty_off_nxt[13:8] = write_data_in[5:0];
			end
			`SEL_FULL_LO: begin
				full_off_nxt[7:0] = write_data_in[7:0];
			end
			default: begin
				full_off_nxt[13:8] = write_data_in[5:0];
			end
			endcase
		end
		if (off_read) begin // see R13
			rd_sel_nxt = rd_sel_r + 2'h1;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			empty_off_r <= `EMPTY_OFFSET_DEFAULT; // see R14
			full_off_r <= `FULL_OFFSET_DEFAULT; // see R15
		end else begin
			empty_off_r <= empty_off_nxt;
			full_off_r <= full_off_nxt;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_sel_r <= `SEL_EMPTY_LO;
			rd_sel_r <= `SEL_EMPTY_LO;
		end else begin
			wr_sel_r <= wr_sel_nxt;
			rd_sel_r <= rd_sel_nxt;
		end
	end

	// ****************************************
	// Flags, all registered
	// ****************************************
	// Single clock: flags follow the next count, so no pointer crosses domains
	wire [ABITS:0] free_nxt = DEPTH_C - count_nxt;
	reg empty_nxt;
	reg full_nxt;
	reg almost_empty_nxt;
	reg almost_full_nxt;

	always @* begin
		empty_nxt = (count_nxt != {(ABITS+1){1'b0}}); // see R10
		full_nxt = (count_nxt != DEPTH_C); // see R7
		almost_empty_nxt = (count_nxt > {1'b0, empty_off_r}); // see R14
		almost_full_nxt = (free_nxt > {1'b0, full_off_r}); // see R15
	end

	// Empty flag on the read side
	always @(posedge ref_clk or negedge rst_n) begin // see R12
		if (!rst_n) begin
			empty_flag_n <= 1'b0; // see R19
		end else begin
			empty_flag_n <= empty_nxt;
		end
	end

	// Full flag on the write side
	always @(posedge ref_clk or negedge rst_n) begin // see R9
		if (!rst_n) begin
			full_indicator_n <= 1'b1;
		end else begin
			full_indicator_n <= full_nxt;
		end
	end

	// Almost-empty flag, registered like the end flags
	always @(posedge ref_clk or negedge rst_n) begin // see R6
		if (!rst_n) begin
			almost_empty_flag_n <= 1'b0;
		end else begin
			almost_empty_flag_n <= almost_empty_nxt;
		end
	end

	// Almost-full flag, registered like the end flags
	always @(posedge ref_clk or negedge rst_n) begin // see R6
		if (!rst_n) begin
			almost_full_flag_n <= 1'b1;
		end else begin
			almost_full_flag_n <= almost_full_nxt;
		end
	end
endmodule // sync_fifo_status_flags

/* File: hw/sync_fifo_status_flags_regs.vh */
`ifndef SYNC_FIFO_STATUS_FLAGS_REGS_VH
`define SYNC_FIFO_STATUS_FLAGS_REGS_VH
// ****************************************
// Geometry and defaults
// ****************************************
`define FIFO_WIDTH 9
`define FIFO_ADDR_BITS 14
`define OFFSET_BITS 14
`define EMPTY_OFFSET_DEFAULT 14'h0007
`define FULL_OFFSET_DEFAULT 14'h0007
// Offset byte select order
`define SEL_EMPTY_LO 2'h0
`define SEL_EMPTY_HI 2'h1
`define SEL_FULL_LO 2'h2
`define SEL_FULL_HI 2'h3
`endif

/* File: testbench/sfsf_properties.sv */
`timescale 1ns/10ps
module sfsf_props #(parameter WIDTH = 9) (
	input logic ref_clk, reset_n, write_enable_a_n, write_enable_b_or_load, read_enable_a_n, read_enable_b_n,
	input logic empty_flag_n, full_indicator_n, almost_empty_flag_n, almost_full_flag_n, load_mode,
	input logic [WIDTH-1:0] read_data_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire e = empty_flag_n, f = full_indicator_n, b = write_enable_b_or_load, w = !write_enable_a_n;
	wire rd = !read_enable_a_n && !read_enable_b_n;
	full_blk_a: assert property (!f && !rd |=> !f) else $error("full lost");
	empty_blk_a: assert property (!e && !w && b |=> !e && $stable(read_data_out)) else $error("empty lost");
	data_hold_a: assert property (!rd && b |=> $stable(read_data_out)) else $error("data moved");
	empty_ae_a: assert property (!e |-> !almost_empty_flag_n) else $error("ae high");
	full_af_a: assert property (!f |-> !almost_full_flag_n) else $error("af high");
	fifo_fill_a: assert property (!e && w && b && !rd |=> e) else $error("no fill");
	fifo_drain_a: assert property (!f && rd && b |=> f) else $error("no drain");
	load_flags_a: assert property (load_mode && !b |=> $stable(e) && $stable(f)) else $error("load moved");
	cover property (!f && rd);
	cover property (!e && rd);
	cover property (load_mode && rd);
endmodule // sfsf_props
bind sync_fifo_status_flags sfsf_props #(.WIDTH(WIDTH)) sfsf_props_i (.*);

/* File: testbench/wr_producer.sv */
`timescale 1ns/10ps
module wr_producer (input logic clk, go, input logic [8:0] d, output logic wen_n = 1, output logic [8:0] wdata = 0);
	// Idle data flips each cycle, so a stale word never looks valid
	always @(posedge clk) begin
		#2;
		wen_n = !go;
		wdata = go ? d : ~wdata;
	end
endmodule // wr_producer

/* File: testbench/tb_sync_fifo_status_flags.sv */
`timescale 1ns/10ps
module tb_sync_fifo_status_flags;
	logic ref_clk = 0, reset_n = 0, write_enable_b_or_load = 1, read_enable_a_n = 1, go = 0, write_enable_a_n;
	logic empty_flag_n, full_indicator_n, almost_empty_flag_n, almost_full_flag_n, load_mode;
	logic [8:0] d = 0, write_data_in, read_data_out, q[$];
	logic [8:0] ob[5] = '{9'h11, 9'h1ff, 9'h22, 9'h33, 9'h44};
	logic [8:0] ex[9] = '{9'h7, 9'h0, 9'h7, 9'h0, 9'h44, 9'h3f, 9'h22, 9'h33, 9'h44};
	wire read_enable_b_n = read_enable_a_n;
	// One device here, so the composite end flags are its own
	wire comp_empty_n = &{empty_flag_n};
	wire comp_full_n = &{full_indicator_n};
	int fails = 0, n_checks = 0, seed = 32'h3168;
	initial forever #50 ref_clk = ~ref_clk;
	wr_producer wr_producer_i (.clk(ref_clk), .go(go), .d(d), .wen_n(write_enable_a_n), .wdata(write_data_in));
	sync_fifo_status_flags #(.ABITS(4)) sync_fifo_status_flags_i (.*);
	// Depth 16: full, almost-empty and almost-full after n stored words
	function [2:0] flg(input int n);
		flg = {n < 16, n > 7, 16 - n > 7};
	endfunction
	task cyc;
		@(posedge ref_clk);
		#1;
	endtask
	task chk(input logic [9:0] s, x);
		n_checks++;
		if (s !== x) begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, s, x);
		end
	endtask
	task rst(input logic b);
		{go, read_enable_a_n, write_enable_b_or_load, reset_n} = {2'b01, b, 1'b0};
		repeat (8) cyc;
		reset_n = 1;
		repeat (3) cyc;
	endtask
	task give_verdict;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#60000;
		fails++;
		give_verdict;
	end
	initial begin
		rst(1);
		chk({empty_flag_n, full_indicator_n, almost_empty_flag_n, almost_full_flag_n, load_mode}, 10'h0a);
		// One write past full must be dropped
		for (int i = 1; i < 18; i++) begin
			d = $random(seed);
			go = 1;
			if (i < 17) q.push_back(d);
			cyc;
			chk({full_indicator_n, almost_empty_flag_n, almost_full_flag_n}, flg(i));
		end
		go = 0;
		read_enable_a_n = 0;
		foreach (q[j]) begin
			cyc;
			chk(read_data_out, q[j]);
		end
		cyc;
		chk({empty_flag_n, read_data_out}, {1'b0, q[15]});
		chk({comp_empty_n, comp_full_n}, 10'h001);
		rst(0);
		read_enable_a_n = 0;
		for (int i = 0; i < 9; i++) begin
			if (i == 4) begin
				read_enable_a_n = 1;
				foreach (ob[j]) begin
					d = ob[j];
					go = 1;
					cyc;
				end
				go = 0;
				cyc;
				read_enable_a_n = 0;
			end
			cyc;
			chk(read_data_out, ex[i]);
		end
		give_verdict;
	end
endmodule // tb_sync_fifo_status_flags
